// ===== bsm_pkg.sv
// Purpose: Constants and carriers for boot strap capture and SDRAM bank select
// Assumes: Single 50 MHz clock, asynchronous active-high reset
// Notes:   Strap codes, window tags and widths are named here; decoded bus widths are literals
// How it works
// - Capture strap pins after reset release as boot configuration
// - Four strap inputs form code, bit 3 MSB
// - 0010 8-bit NAND 2K, 0111 8-bit NAND 512
// - 0011 16-bit NAND 2K, 0100 16-bit NAND 512
// - 0x80000000-0x8fffffff asserts bank zero select
// - Bank one select window starts at 0x90000000
// - Each bank is 32-bit, memory clock 133MHz
package bsm_pkg;

  localparam int STRAP_W = 4;
  localparam logic [STRAP_W-1:0] STRAP_DEFAULT = 4'h7;
  localparam logic [STRAP_W-1:0] CODE_SERIAL   = 4'h0;
  localparam logic [STRAP_W-1:0] CODE_NAND8_2K = 4'h2;
  localparam logic [STRAP_W-1:0] CODE_NAND16_2K = 4'h3;
  localparam logic [STRAP_W-1:0] CODE_NAND16_512 = 4'h4;
  localparam logic [STRAP_W-1:0] CODE_NOR16    = 4'h5;
  localparam logic [STRAP_W-1:0] CODE_STATIC32 = 4'h6;
  localparam logic [STRAP_W-1:0] CODE_NAND8_512 = 4'h7;

  localparam int ADDR_W = 32;
  localparam int WINDOW_LSB = 28;
  localparam logic [3:0] BANK0_TAG = 4'h8;
  localparam logic [3:0] BANK1_TAG = 4'h9;

  localparam int SDRAM_DATA_W = 32;
  localparam int SDRAM_CHIP_W = 16;
  localparam int SDRAM_CLK_MHZ = 133;
  localparam int SYS_CLK_MHZ   = 50;

  typedef enum logic [3:0] {
    BSM_SRC_SERIAL,
    BSM_SRC_NAND,
    BSM_SRC_NOR16,
    BSM_SRC_STATIC32,
    BSM_SRC_RESERVED
  } bsm_source_e;

  typedef struct packed {
    bsm_source_e      source;
    logic [4:0]       busWidth;
    logic             largePage;
    logic             staticChipSelectZero;
    logic             reserved;
    logic [STRAP_W-1:0] code;
  } bsm_boot_s;

  typedef struct packed {
    logic               valid;
    logic [ADDR_W-1:0]  addr;
  } bsm_access_s;

  typedef struct packed {
    logic sdramBank0Select;
    logic sdramBank1Select;
    logic bank1Enabled;
  } bsm_select_s;

endpackage

// ===== bsm_bank_decode.sv
// Purpose: Decode one SDRAM bank window from an address
// Assumes: Window is the top address nibble
// Notes:   Instantiated once per bank
`timescale 1ns/100ps
`default_nettype none
module bsm_bank_decode #(
  parameter logic [3:0] TAG = 4'h8
) (
  input  wire logic                      enable,
  input  wire bsm_pkg::bsm_access_s      access,
  output logic                           hit
);

  // Window match on upper nibble
  assign hit = enable & access.valid &
               (access.addr[bsm_pkg::ADDR_W-1:bsm_pkg::WINDOW_LSB] == TAG);

endmodule
`default_nettype wire

// ===== bsm_boot_select.sv
// Purpose: Strap capture, boot source decode, SDRAM bank selects
// Assumes: Strap pins are asynchronous and stable around reset release
// Notes:   Selects are registered, one cycle after the access
`timescale 1ns/100ps
`default_nettype none
module bsm_boot_select (
  input  wire logic                            clock,
  input  wire logic                            sys_rst,
  input  wire logic [bsm_pkg::STRAP_W-1:0]     bootStrap,
  input  wire logic                            bank1Populated,
  input  wire bsm_pkg::bsm_access_s            access,
  output bsm_pkg::bsm_boot_s                   bootConfig,
  output logic                                 bootConfigValid,
  output bsm_pkg::bsm_select_s                 memSelect
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [bsm_pkg::STRAP_W-1:0] strapMeta_reg;
  logic [bsm_pkg::STRAP_W-1:0] strapSync_reg;
  logic                        popMeta_reg;
  logic                        popSync_reg;

  // Two stages before any logic reads the straps
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      strapMeta_reg <= bsm_pkg::STRAP_DEFAULT;
      strapSync_reg <= bsm_pkg::STRAP_DEFAULT;
      popMeta_reg   <= 1'b0;
      popSync_reg   <= 1'b0;
    end
    else
    begin
      strapMeta_reg <= bootStrap;
      strapSync_reg <= strapMeta_reg;
      popMeta_reg   <= bank1Populated;
      popSync_reg   <= popMeta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Capture sequencer

  typedef enum logic [1:0] {
    CAP_SETTLE,
    CAP_FILL,
    CAP_TAKE,
    CAP_DONE
  } bsm_cap_e;

  bsm_cap_e                    capState_reg;
  bsm_cap_e                    capState_next;
  logic [bsm_pkg::STRAP_W-1:0] code_reg;
  logic [bsm_pkg::STRAP_W-1:0] code_next;
  logic                        bank1En_reg;
  logic                        bank1En_next;

  // Two edges fill the sync pipe, then latch once
  always_comb
  begin
    capState_next = capState_reg;
    code_next     = code_reg;
    bank1En_next  = bank1En_reg;
    case (capState_reg)
      CAP_SETTLE: capState_next = CAP_FILL;
      CAP_FILL:   capState_next = CAP_TAKE; // Sync stage one now holds the pins
      CAP_TAKE:
      begin
        code_next     = strapSync_reg;
        bank1En_next  = popSync_reg;
        capState_next = CAP_DONE;
      end
      CAP_DONE: capState_next = CAP_DONE;
      default:  capState_next = CAP_SETTLE;
    endcase
  end

  // Held until next reset
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      capState_reg <= CAP_SETTLE;
      code_reg     <= bsm_pkg::STRAP_DEFAULT;
      bank1En_reg  <= 1'b0;
    end
    else
    begin
      capState_reg <= capState_next;
      code_reg     <= code_next;
      bank1En_reg  <= bank1En_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Boot source decode

  bsm_pkg::bsm_boot_s boot_next;
  bsm_pkg::bsm_boot_s boot_reg;

  // Map code to source, width, page size
  always_comb
  begin
    boot_next                      = '0;
    boot_next.code                 = code_reg;
    boot_next.source               = bsm_pkg::BSM_SRC_RESERVED;
    boot_next.reserved             = 1'b1;
    case (code_reg)
      bsm_pkg::CODE_SERIAL:
      begin
        boot_next.source   = bsm_pkg::BSM_SRC_SERIAL;
        boot_next.reserved = 1'b0;
      end
      bsm_pkg::CODE_NAND8_2K:
      begin
        boot_next.source    = bsm_pkg::BSM_SRC_NAND;
        boot_next.busWidth  = 5'h08;
        boot_next.largePage = 1'b1;
        boot_next.reserved  = 1'b0;
      end
      bsm_pkg::CODE_NAND8_512:
      begin
        boot_next.source               = bsm_pkg::BSM_SRC_NAND;
        boot_next.busWidth             = 5'h08;
        boot_next.staticChipSelectZero = 1'b1;
        boot_next.reserved             = 1'b0;
      end
      bsm_pkg::CODE_NAND16_2K:
      begin
        boot_next.source    = bsm_pkg::BSM_SRC_NAND;
        boot_next.busWidth  = 5'h10;
        boot_next.largePage = 1'b1;
        boot_next.reserved  = 1'b0;
      end
      bsm_pkg::CODE_NAND16_512:
      begin
        boot_next.source   = bsm_pkg::BSM_SRC_NAND;
        boot_next.busWidth = 5'h10;
        boot_next.reserved = 1'b0;
      end
      bsm_pkg::CODE_NOR16:
      begin
        boot_next.source               = bsm_pkg::BSM_SRC_NOR16;
        boot_next.busWidth             = 5'h10;
        boot_next.staticChipSelectZero = 1'b1;
        boot_next.reserved             = 1'b0;
      end
      bsm_pkg::CODE_STATIC32:
      begin
        boot_next.source               = bsm_pkg::BSM_SRC_STATIC32;
        boot_next.busWidth             = 5'h00;
        boot_next.staticChipSelectZero = 1'b1;
        boot_next.reserved             = 1'b0;
      end
      default:
      begin
        boot_next.source   = bsm_pkg::BSM_SRC_RESERVED;
        boot_next.reserved = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // SDRAM bank decode

  logic               hit0;
  logic               hit1;
  bsm_pkg::bsm_select_s sel_next;
  bsm_pkg::bsm_select_s sel_reg;
  logic               valid_next;
  logic               valid_reg;

  // Bank zero window
  bsm_bank_decode #(
    .TAG (bsm_pkg::BANK0_TAG)
  ) u_bank0 (
    .enable (1'b1),
    .access (access),
    .hit    (hit0)
  );

  // Bank one window, only when populated
  bsm_bank_decode #(
    .TAG (bsm_pkg::BANK1_TAG)
  ) u_bank1 (
    .enable (bank1En_reg),
    .access (access),
    .hit    (hit1)
  );

  // Selects and valid flag
  always_comb
  begin
    sel_next.sdramBank0Select = hit0;
    sel_next.sdramBank1Select = hit1;
    sel_next.bank1Enabled     = bank1En_reg;
    valid_next                = (capState_reg == CAP_DONE);
  end

  // Registered outputs
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      boot_reg  <= '0;
      sel_reg   <= '0;
      valid_reg <= 1'b0;
    end
    else
    begin
      boot_reg  <= boot_next;
      sel_reg   <= sel_next;
      valid_reg <= valid_next;
    end
  end

  assign bootConfig      = boot_reg;
  assign bootConfigValid = valid_reg;
  assign memSelect       = sel_reg;

endmodule
`default_nettype wire

// ===== bsm_boot_select_properties.sv
// Purpose: Checker for strap capture, boot decode and bank selects
// Assumes: Single clock domain, sys_rst asynchronous active high
// Notes:   Bound onto bsm_boot_select, sees ports only
`timescale 1ns/100ps
`default_nettype none
module bsm_boot_select_properties (
  input wire logic                        clock,
  input wire logic                        sys_rst,
  input wire logic [bsm_pkg::STRAP_W-1:0] bootStrap,
  input wire logic                        bank1Populated,
  input wire bsm_pkg::bsm_access_s        access,
  input wire bsm_pkg::bsm_boot_s          bootConfig,
  input wire logic                        bootConfigValid,
  input wire bsm_pkg::bsm_select_s        memSelect
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  // Address window selects
  property p_bank0; access.valid && access.addr[31:28] == 4'h8 |=> memSelect.sdramBank0Select;
  endproperty
  a_bank0: assert property (p_bank0) else $error("bank zero select missing");
  property p_nobank0; !(access.valid && access.addr[31:28] == 4'h8) |=> !memSelect.sdramBank0Select;
  endproperty
  a_nobank0: assert property (p_nobank0) else $error("stray bank zero select");
  property p_nobank1; !(access.valid && access.addr[31:28] == 4'h9) |=> !memSelect.sdramBank1Select;
  endproperty
  a_nobank1: assert property (p_nobank1) else $error("stray bank one select");
  property p_bank1; bootConfigValid && memSelect.bank1Enabled && access.valid
    && access.addr[31:28] == 4'h9 |=> memSelect.sdramBank1Select;
  endproperty
  a_bank1: assert property (p_bank1) else $error("bank one select missing");
  property p_b1en; $rose(bootConfigValid) |-> memSelect.bank1Enabled == $past(bank1Populated);
  endproperty
  a_b1en: assert property (p_b1en) else $error("bank one enable wrong");
  ////////////////////////////////////////////////////////////////////////////
  // Captured boot configuration
  property p_hold; bootConfigValid |=> bootConfigValid && $stable(bootConfig); endproperty
  a_hold: assert property (p_hold) else $error("boot config changed");
  property p_code; $rose(bootConfigValid) |-> bootConfig.code == $past(bootStrap); endproperty
  a_code: assert property (p_code) else $error("captured code wrong");
  property p_nand; bootConfigValid && bootConfig.code inside {4'h2, 4'h3, 4'h4, 4'h7}
    |-> bootConfig.source == bsm_pkg::BSM_SRC_NAND && bootConfig.largePage == (bootConfig.code < 4'h4);
  endproperty
  a_nand: assert property (p_nand) else $error("nand decode wrong");
  property p_width; bootConfigValid && bootConfig.source == bsm_pkg::BSM_SRC_NAND
    |-> bootConfig.busWidth == (bootConfig.code inside {4'h2, 4'h7} ? 5'h08 : 5'h10);
  endproperty
  a_width: assert property (p_width) else $error("nand width wrong");
  property p_rsvd; bootConfigValid |-> bootConfig.reserved == (bootConfig.code == 4'h1 || bootConfig.code[3]);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved flag wrong");
  property p_scz; bootConfigValid
    |-> bootConfig.staticChipSelectZero == (bootConfig.code inside {4'h5, 4'h6, 4'h7});
  endproperty
  a_scz: assert property (p_scz) else $error("chip select zero flag wrong");
endmodule
bind bsm_boot_select bsm_boot_select_properties u_bsm_boot_select_properties (.clock, .sys_rst,
  .bootStrap, .bank1Populated, .access, .bootConfig, .bootConfigValid, .memSelect);
`default_nettype wire

// ===== bsm_strap_board.sv
// Purpose: Board strap resistors feeding the boot strap pins
// Assumes: Straps are static levels
// Notes:   useDefault gives the factory strapping
`timescale 1ns/100ps
`default_nettype none
module bsm_strap_board (
  input  wire logic       useDefault,
  input  wire logic [3:0] want,
  input  wire logic       dense,
  output logic [3:0]      bootStrap,
  output logic            bank1Populated
);
  // Factory strapping or chosen code
  assign bootStrap = useDefault ? bsm_pkg::STRAP_DEFAULT : want;
  assign bank1Populated = dense;
endmodule
`default_nettype wire

// ===== bsm_boot_select_tb.sv
// Purpose: Self-checking bench for bsm_boot_select
// Assumes: 50 MHz clock, inputs driven on falling edge
// Notes:   Expectations queued by driver, checked by monitor
`timescale 1ns/100ps
`default_nettype none
module bsm_boot_select_tb;
  logic clock = 1'b0, sys_rst = 1'b1, useDefault = 1'b1, dense = 1'b0, d, pend = 1'b0, got;
  logic [3:0] want = 4'h0, bootStrap, n;
  logic bank1Populated, bootConfigValid;
  bsm_pkg::bsm_access_s access = '0;
  bsm_pkg::bsm_boot_s bootConfig;
  bsm_pkg::bsm_select_s memSelect;
  logic [15:0] cfgQ[$];
  logic [1:0] selQ[$];
  logic [15:0] e;
  int fails = 0, cmp_count = 0, k;
  bsm_strap_board u_bsm_strap_board (.useDefault, .want, .dense, .bootStrap, .bank1Populated);
  bsm_boot_select u_bsm_boot_select (.clock, .sys_rst, .bootStrap, .bank1Populated, .access,
    .bootConfig, .bootConfigValid, .memSelect);
  ////////////////////////////////////////////////////////////////////////////
  // Clock and shared tasks
  initial forever #10 clock = ~clock;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d fails %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Expected {code, full, source, busWidth, largePage, reserved}
  function automatic logic [15:0] expCfg(input logic [3:0] c);
    case (c)
      4'h0: return {c, 1'b0, bsm_pkg::BSM_SRC_SERIAL, 7'h00};
      4'h2: return {c, 1'b1, bsm_pkg::BSM_SRC_NAND, 5'h08, 2'b10};
      4'h3: return {c, 1'b1, bsm_pkg::BSM_SRC_NAND, 5'h10, 2'b10};
      4'h4: return {c, 1'b1, bsm_pkg::BSM_SRC_NAND, 5'h10, 2'b00};
      4'h5: return {c, 1'b1, bsm_pkg::BSM_SRC_NOR16, 5'h10, 2'b00};
      4'h6: return {c, 1'b1, bsm_pkg::BSM_SRC_STATIC32, 5'h00, 2'b00};
      4'h7: return {c, 1'b1, bsm_pkg::BSM_SRC_NAND, 5'h08, 2'b00};
      default: return {c, 1'b0, bsm_pkg::BSM_SRC_RESERVED, 7'h01};
    endcase
  endfunction
  // Reset with straps held, then wait for capture
  task automatic boot(input logic [3:0] c);
    @(negedge clock);
    sys_rst = 1'b1;
    d = dense;
    repeat (5) @(negedge clock);
    got = 1'b0;
    cfgQ.push_back(expCfg(c));
    sys_rst = 1'b0;
    for (int i = 0; i < 8 && !got; i++) @(negedge clock);
    if (!got) chk("bootConfigValid", 32'(bootConfigValid), 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Monitor: oldest note against each result
  always @(posedge clock) pend <= access.valid === 1'b1 && !sys_rst;
  always @(negedge clock)
  begin
    if (bootConfigValid === 1'b1 && !got && cfgQ.size() > 0)
    begin
      got = 1'b1;
      e = cfgQ.pop_front();
      chk("code", 32'(bootConfig.code), 32'(e[15:12]));
      chk("source", 32'(bootConfig.source), 32'(e[10:7]));
      chk("reserved", 32'(bootConfig.reserved), 32'(e[0]));
      if (e[11]) chk("busWidth", 32'(bootConfig.busWidth), 32'(e[6:2]));
      if (e[11]) chk("largePage", 32'(bootConfig.largePage), 32'(e[1]));
      chk("staticChipSelectZero", 32'(bootConfig.staticChipSelectZero),
        32'(e[15:12] inside {4'h5, 4'h6, 4'h7}));
    end
    if (pend && selQ.size() > 0)
    begin
      chk("select", 32'({memSelect.sdramBank0Select, memSelect.sdramBank1Select}),
        32'(selQ.pop_front()));
      chk("bank1Enabled", 32'(memSelect.bank1Enabled), 32'(d));
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: default board, then every code
  initial
  begin
    void'($urandom(32'h0a3a));
    boot(bsm_pkg::STRAP_DEFAULT);
    useDefault = 1'b0;
    for (int c = 0; c < 16; c++)
    begin
      want = 4'(c);
      dense = 1'($urandom);
      boot(4'(c));
      want = 4'($urandom);
      dense = ~dense;
      repeat (20)
      begin
        @(negedge clock);
        n = 4'h7 + 4'($urandom_range(3));
        k = $urandom_range(2);
        access.addr = {n, k == 0 ? 28'h0 : k == 1 ? 28'hfffffff : 28'($urandom)};
        access.valid = $urandom_range(3) != 0;
        if (access.valid) selQ.push_back({n == 4'h8, n == 4'h9 && d});
      end
      @(negedge clock);
      access = '0;
      chk("heldCode", 32'(bootConfig.code), 32'(c));
    end
    repeat (2) @(negedge clock);
    final_report();
  end
  // Watchdog
  initial
  begin
    #400000;
    fails++;
    final_report();
  end
endmodule
`default_nettype wire
